// ### hw/ssr_supervisor.sv
// Supervisory logic of a battery-backed security supervisor: supply
// selection, reset timing, manual reset, power-fail and battery-low flags.
// Assumes comparator results arrive as asynchronous digital levels and
// that the security alarm is generated outside and only consumed here.
`timescale 1ns/1ps

module ssr_supervisor
#(
   parameter ssr_pkg::ssr_variant_e VARIANT   = ssr_pkg::SSR_ALARM_KEEP_ON,
   parameter ssr_pkg::ssr_bat_thr_e BAT_THR   = ssr_pkg::SSR_BAT_2V5,
   parameter int unsigned  RESET_TIMEOUT_CYCLES =
      ssr_pkg::RESET_TIMEOUT_CYCLES,
   parameter int unsigned  DEBOUNCE_CYCLES    = ssr_pkg::DEBOUNCE_CYCLES
)
(
   input  wire logic                     ref_clk,
   input  wire logic                     rst_n,
   input  wire ssr_pkg::ssr_sense_s      sense,
   output logic                          reset_out_n,
   output logic                          reset_out_oe,
   output logic                          power_fail_flag_n,
   output logic                          power_fail_flag_oe,
   output logic                          battery_low_flag_n,
   output logic                          battery_low_flag_oe,
   output logic                          supply_switch_n,
   output ssr_pkg::ssr_supply_ctl_s      supply_ctl
);

   localparam int unsigned TMR_W = $clog2(RESET_TIMEOUT_CYCLES + 1);
   localparam int unsigned DEB_W = $clog2(DEBOUNCE_CYCLES + 1);
   localparam logic [TMR_W-1:0] TMR_LAST =
      TMR_W'(RESET_TIMEOUT_CYCLES);
   localparam logic [DEB_W-1:0] DEB_LAST =
      DEB_W'(DEBOUNCE_CYCLES);

   // Synchronisers start at the idle level of each pin, so neither the
   // alarm nor the button reads as active for the first clocks after reset
   localparam ssr_pkg::ssr_sense_s SYNC_IDLE = '{
      security_alarm_n : 1'b1,
      manual_reset_n   : 1'b1,
      default          : 1'b0
   };

   // Synchronised inputs
   ssr_pkg::ssr_sense_s          raw;
   ssr_pkg::ssr_sense_s          sync;
   logic [ssr_pkg::SENSE_W-1:0]  sync_ff1;
   logic [ssr_pkg::SENSE_W-1:0]  sync_ff2;
   logic [ssr_pkg::SENSE_W-1:0]  sync_ff3;
   logic [ssr_pkg::SENSE_W-1:0]  sync_val;

   // Internal state
   logic                         on_battery;
   logic                         mr_stable_n;
   logic [DEB_W-1:0]             deb_cnt;
   logic [TMR_W-1:0]             tmr_cnt;
   logic                         reset_active;
   logic                         powerup_pending;
   logic                         battery_low;
   logic                         battery_ok;
   logic                         alarm;
   logic                         hold_reset;
   logic                         next_switch_n;
   ssr_pkg::ssr_supply_ctl_s     next_supply_ctl;

   assign raw = sense;

   // Three stages per bit; a change counts once stages two and three agree.
   // Bits settle independently, so two inputs that move together may be
   // seen one clock apart.
   genvar gi;
   generate
      for (gi = 0; gi < ssr_pkg::SENSE_W; gi = gi + 1)
      begin : g_sync
         always_ff @(posedge ref_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               sync_ff1[gi] <= SYNC_IDLE[gi];
               sync_ff2[gi] <= SYNC_IDLE[gi];
               sync_ff3[gi] <= SYNC_IDLE[gi];
               sync_val[gi] <= SYNC_IDLE[gi];
            end
            else
            begin
               sync_ff1[gi] <= raw[gi];
               sync_ff2[gi] <= sync_ff1[gi];
               sync_ff3[gi] <= sync_ff2[gi];
               if (sync_ff2[gi] == sync_ff3[gi])
               begin
                  sync_val[gi] <= sync_ff3[gi];
               end
            end
         end
      end
   endgenerate

   assign sync = sync_val;

   // Active-low alarm is formed upstream from tamper and trip detectors
   assign alarm = !sync.security_alarm_n;

   // Build-time battery threshold picks one comparator.
   // An unlisted option falls back to the middle threshold.
   always_comb
   begin
      case (BAT_THR)
         ssr_pkg::SSR_BAT_2V3: battery_ok = sync.battery_above_2v3;
         ssr_pkg::SSR_BAT_2V5: battery_ok = sync.battery_above_2v5;
         ssr_pkg::SSR_BAT_3V2: battery_ok = sync.battery_above_3v2;
         default:              battery_ok = sync.battery_above_2v5;
      endcase
   end

   // Supply selection; the switch point sits above the switchover level,
   // which gives the hysteresis against oscillation on recovery
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         on_battery <= ssr_pkg::RST_ON_BATTERY;
      end
      else if (!sync.vcc_above_switchover && !sync.vcc_above_battery)
      begin
         on_battery <= 1'b1;
      end
      else if (sync.vcc_above_switch_point)
      begin
         on_battery <= 1'b0;
      end
   end

   // Manual reset debounce: accept a new level only after it has held
   // for the whole window, so switch bounce never reaches the timer.
   // An undriven pin is pulled up at the pad and arrives here as high.
   // A press shorter than the window is lost; that is the price of
   // needing no filter outside.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mr_stable_n <= ssr_pkg::RST_MR_STABLE_N;
         deb_cnt     <= '0;
      end
      else if (sync.manual_reset_n == mr_stable_n)
      begin
         deb_cnt <= '0;
      end
      else if (deb_cnt == DEB_LAST)
      begin
         mr_stable_n <= sync.manual_reset_n;
         deb_cnt     <= '0;
      end
      else
      begin
         deb_cnt <= deb_cnt + DEB_W'(1);
      end
   end

   // Manual input is disabled while running from battery
   assign hold_reset = !sync.vcc_above_reset
                    || (!mr_stable_n && !on_battery);

   // Reset timer: any holding condition clears it, so every release
   // comes a full timeout after the last cause went away.
   // The count rests at its last value while released; the next hold
   // clears it.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tmr_cnt      <= '0;
         reset_active <= ssr_pkg::RST_RESET_ACTIVE;
      end
      else if (hold_reset)
      begin
         tmr_cnt      <= '0;
         reset_active <= 1'b1;
      end
      else if (reset_active)
      begin
         if (tmr_cnt == TMR_LAST)
         begin
            reset_active <= 1'b0;
         end
         else
         begin
            tmr_cnt <= tmr_cnt + TMR_W'(1);
         end
      end
   end

   // Power-up window: from supply below reset until the timer releases.
   // A manual reset after power-up therefore does not repeat the test.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         powerup_pending <= ssr_pkg::RST_POWERUP_PENDING;
      end
      else if (!sync.vcc_above_reset)
      begin
         powerup_pending <= 1'b1;
      end
      else if (!reset_active)
      begin
         powerup_pending <= 1'b0;
      end
   end

   // Battery test; set and release never coincide, as the test needs
   // the supply above the reset threshold
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         battery_low <= ssr_pkg::RST_BATTERY_LOW;
      end
      else if (!sync.vcc_above_reset)
      begin
         battery_low <= 1'b0;
      end
      else if (powerup_pending && reset_active && !battery_ok)
      begin
         battery_low <= 1'b1;
      end
   end

   // Supply switch control and indicator.
   // Only the two cutting variants let the alarm override the output.
   always_comb
   begin
      next_supply_ctl = ssr_pkg::RST_SUPPLY_CTL;
      next_supply_ctl.out_from_battery    = on_battery;
      next_supply_ctl.out_on              = 1'b1;
      next_supply_ctl.pullup_from_battery = on_battery;
      next_switch_n = on_battery;
      case (VARIANT)
         ssr_pkg::SSR_ALARM_KEEP_ON:
         begin
            next_supply_ctl.pullup_on = 1'b0;
            next_supply_ctl.reference_on =
               sync.vcc_above_switchover;
            next_supply_ctl.reference_pulldown =
               !sync.vcc_above_switchover;
         end
         ssr_pkg::SSR_ALARM_HIGH_Z:
         begin
            next_supply_ctl.pullup_on = 1'b1;
            next_supply_ctl.reference_pulldown = 1'b0;
            if (alarm)
            begin
               next_supply_ctl.out_on     = 1'b0;
               next_supply_ctl.out_high_z = 1'b1;
               next_switch_n              = 1'b1;
            end
         end
         ssr_pkg::SSR_ALARM_GROUND:
         begin
            next_supply_ctl.pullup_on = 1'b1;
            next_supply_ctl.reference_pulldown = 1'b0;
            if (alarm)
            begin
               next_supply_ctl.out_on     = 1'b0;
               next_supply_ctl.out_ground = 1'b1;
               next_switch_n              = 1'b1;
            end
         end
         default:
         begin
            next_supply_ctl.pullup_on = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         supply_ctl      <= ssr_pkg::RST_SUPPLY_CTL;
         supply_switch_n <= ssr_pkg::RST_ON_BATTERY;
      end
      else
      begin
         supply_ctl      <= next_supply_ctl;
         supply_switch_n <= next_switch_n;
      end
   end

   // Open-drain flags: the level shown and the pull-low enable agree.
   // Registering them costs a clock but keeps glitches off the pins.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reset_out_n        <= 1'b0;
         reset_out_oe       <= 1'b1;
         power_fail_flag_n  <= 1'b0;
         power_fail_flag_oe <= 1'b1;
         battery_low_flag_n <= 1'b1;
         battery_low_flag_oe <= 1'b0;
      end
      else
      begin
         reset_out_n  <= !reset_active;
         reset_out_oe <= reset_active;
         // Comparator is off on battery, so the flag is forced low
         power_fail_flag_n  <= sync.power_fail_sense_ok
                            && sync.vcc_above_switchover
                            && !on_battery;
         power_fail_flag_oe <= !(sync.power_fail_sense_ok
                            && sync.vcc_above_switchover
                            && !on_battery);
         battery_low_flag_n  <= !battery_low;
         battery_low_flag_oe <= battery_low;
      end
   end

endmodule

// ### hw/ssr_pkg.sv
// Shared constants and types for the security supervisor reset logic.
// Assumes a single 25 MHz timer clock and digital comparator results.
package ssr_pkg;

   // Timer clock
   localparam int unsigned CLK_HZ              = 25_000_000;
   localparam int unsigned CLK_PERIOD_NS       = 40;

   // Reset timeout, in milliseconds, and its cycle count
   localparam int unsigned RESET_TIMEOUT_MS    = 200;
   localparam int unsigned RESET_TIMEOUT_CYCLES =
      (CLK_HZ / 1000) * RESET_TIMEOUT_MS;

   // Manual reset debounce window, in microseconds, and its cycle count
   localparam int unsigned DEBOUNCE_US         = 5000;
   localparam int unsigned DEBOUNCE_CYCLES     =
      (CLK_HZ / 1_000_000) * DEBOUNCE_US;

   // Synchroniser depth for asynchronous inputs
   localparam int unsigned SYNC_STAGES         = 3;

   // Number of synchronised comparator and pin inputs
   localparam int unsigned SENSE_W             = 10;

   // Reset values of the flags and modes
   localparam logic RST_ON_BATTERY             = 1'b1;
   localparam logic RST_RESET_ACTIVE           = 1'b1;
   localparam logic RST_BATTERY_LOW            = 1'b0;
   localparam logic RST_POWERUP_PENDING        = 1'b1;
   localparam logic RST_MR_STABLE_N            = 1'b1;

   // Behaviour of the switched supply during a security alarm
   typedef enum logic [1:0]
   {
      SSR_ALARM_KEEP_ON = 2'b00,
      SSR_ALARM_HIGH_Z  = 2'b01,
      SSR_ALARM_GROUND  = 2'b10
   } ssr_variant_e;

   // Battery test threshold build option
   typedef enum logic [1:0]
   {
      SSR_BAT_2V3 = 2'b00,
      SSR_BAT_2V5 = 2'b01,
      SSR_BAT_3V2 = 2'b10
   } ssr_bat_thr_e;

   // Comparator results and pins, one bit per threshold (high = above)
   typedef struct packed
   {
      logic vcc_above_reset;
      logic vcc_above_switchover;
      logic vcc_above_battery;
      logic vcc_above_switch_point;
      logic battery_above_2v3;
      logic battery_above_2v5;
      logic battery_above_3v2;
      logic power_fail_sense_ok;
      logic security_alarm_n;
      logic manual_reset_n;
   } ssr_sense_s;

   // Control of the analog switches on the supply pins
   typedef struct packed
   {
      logic out_from_battery;
      logic out_on;
      logic out_high_z;
      logic out_ground;
      logic pullup_on;
      logic pullup_from_battery;
      logic reference_on;
      logic reference_pulldown;
   } ssr_supply_ctl_s;

   localparam ssr_supply_ctl_s RST_SUPPLY_CTL = '{
      out_from_battery    : 1'b1,
      out_on              : 1'b1,
      out_high_z          : 1'b0,
      out_ground          : 1'b0,
      pullup_on           : 1'b0,
      pullup_from_battery : 1'b1,
      reference_on        : 1'b0,
      reference_pulldown  : 1'b1
   };

endpackage

// ### verification/ssr_supervisor_sva.sv
// Output checker for the supervisor, bound to every instance.
// Assumes the bench holds each sense level for several clocks.
`timescale 1ns/1ps

module ssr_supervisor_sva
#(
   parameter ssr_pkg::ssr_variant_e VARIANT = ssr_pkg::SSR_ALARM_KEEP_ON,
   parameter int unsigned RESET_TIMEOUT_CYCLES = 20,
   parameter int unsigned DEBOUNCE_CYCLES = 4
)
(
   input wire logic                     ref_clk,
   input wire logic                     rst_n,
   input wire ssr_pkg::ssr_sense_s      sense,
   input wire logic                     reset_out_n,
   input wire logic                     reset_out_oe,
   input wire logic                     power_fail_flag_n,
   input wire logic                     power_fail_flag_oe,
   input wire logic                     battery_low_flag_n,
   input wire logic                     battery_low_flag_oe,
   input wire logic                     supply_switch_n,
   input wire ssr_pkg::ssr_supply_ctl_s supply_ctl
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   logic        keep;
   int unsigned low_cnt;
   int unsigned mr_cnt;

   assign keep = (VARIANT == ssr_pkg::SSR_ALARM_KEEP_ON);

   // Length of the current reset pulse and of the current button press
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         low_cnt <= 0;
      else
         low_cnt <= reset_out_n ? 0 : low_cnt + 1;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         mr_cnt <= 0;
      else
         mr_cnt <= sense.manual_reset_n ? 0 : mr_cnt + 1;
   end

   AST_OE_MATCH: assert property (reset_out_oe == !reset_out_n)
      else $error("reset enable does not match reset level");
   AST_VCC_HOLD: assert property (
      $fell(sense.vcc_above_reset) |-> ##[1:8] !reset_out_n)
      else $error("reset not asserted after supply drop");
   AST_MIN_LOW: assert property (
      $rose(reset_out_n) |-> low_cnt >= RESET_TIMEOUT_CYCLES)
      else $error("reset pulse shorter than timeout");
   AST_PF_SENSE: assert property (
      !sense.power_fail_sense_ok [*7] |-> !power_fail_flag_n)
      else $error("power-fail flag high with sense low");
   AST_BAT_DROP: assert property (
      !sense.vcc_above_reset [*7] |-> battery_low_flag_n)
      else $error("battery-low flag held with supply low");
   AST_BATT_IND: assert property (
      supply_ctl.out_from_battery |-> supply_switch_n)
      else $error("indicator low while fed from battery");
   AST_KEEP_IND: assert property (keep |->
      supply_switch_n == supply_ctl.out_from_battery && supply_ctl.out_on)
      else $error("keep-on output or indicator wrong");
   AST_ALARM_FORCE: assert property (
      supply_ctl.out_high_z || supply_ctl.out_ground
      |-> supply_switch_n && !supply_ctl.out_on)
      else $error("alarm state without forced indicator");
   AST_REF_OFF: assert property (
      (keep && !sense.vcc_above_switchover) [*7]
      |-> !supply_ctl.reference_on && supply_ctl.reference_pulldown)
      else $error("reference still on below switchover");
   AST_PULLUP_SRC: assert property (!keep |->
      supply_ctl.pullup_from_battery == supply_ctl.out_from_battery)
      else $error("pull-up source differs from output source");
   AST_MR_HOLD: assert property (
      mr_cnt > DEBOUNCE_CYCLES + 8 && !supply_ctl.out_from_battery
      |-> !reset_out_n)
      else $error("reset released while button held");
endmodule

bind ssr_supervisor ssr_supervisor_sva
#(
   .VARIANT              (VARIANT),
   .RESET_TIMEOUT_CYCLES (RESET_TIMEOUT_CYCLES),
   .DEBOUNCE_CYCLES      (DEBOUNCE_CYCLES)
)
i_ssr_supervisor_sva
(
   .ref_clk(ref_clk), .rst_n(rst_n), .sense(sense),
   .reset_out_n(reset_out_n), .reset_out_oe(reset_out_oe),
   .power_fail_flag_n(power_fail_flag_n),
   .power_fail_flag_oe(power_fail_flag_oe),
   .battery_low_flag_n(battery_low_flag_n),
   .battery_low_flag_oe(battery_low_flag_oe),
   .supply_switch_n(supply_switch_n), .supply_ctl(supply_ctl)
);

// ### verification/ssr_host_model.sv
// Host side of the open-drain flags: board pull-ups resolve each line.
// Assumes one enable bit per supervisor instance, high while pulling low.
`timescale 1ns/1ps

module ssr_host_model
(
   input wire logic [2:0] reset_oe,
   input wire logic [2:0] fail_oe,
   input wire logic [2:0] batt_oe,
   output logic     [2:0] reset_line,
   output logic     [2:0] fail_line,
   output logic     [2:0] batt_line
);
   // Released lines go to the pull-up level, never the last driven value
   assign reset_line = ~reset_oe;
   assign fail_line  = ~fail_oe;
   assign batt_line  = ~batt_oe;
endmodule

// ### verification/ssr_supervisor_bench.sv
// Bench: the three alarm variants side by side, each with its own
// battery threshold, driven by one sense bus; flags read through the host, supply controls and levels directly.
// Assumes short timeout and debounce counts given at instantiation.
`timescale 1ns/1ps

module ssr_supervisor_bench;
   localparam int T = 20;

   logic                     ref_clk;
   logic                     rst_n;
   ssr_pkg::ssr_sense_s      sense;
   logic [2:0]               rst_o, rst_oe, pf_o, pf_oe, bl_o, bl_oe, sw_o;
   logic [2:0]               rst_line, pf_line, bl_line;
   ssr_pkg::ssr_supply_ctl_s ctl [3];
   int                       failures;
   int                       checks;

   for (genvar i = 0; i < 3; i++)
   begin : g_var
      ssr_supervisor
      #(
         .VARIANT              (ssr_pkg::ssr_variant_e'(i)),
         .BAT_THR              (ssr_pkg::ssr_bat_thr_e'(i)),
         .RESET_TIMEOUT_CYCLES (T),
         .DEBOUNCE_CYCLES      (4)
      )
      i_ssr_supervisor
      (
         .ref_clk(ref_clk), .rst_n(rst_n), .sense(sense),
         .reset_out_n(rst_o[i]), .reset_out_oe(rst_oe[i]),
         .power_fail_flag_n(pf_o[i]), .power_fail_flag_oe(pf_oe[i]),
         .battery_low_flag_n(bl_o[i]), .battery_low_flag_oe(bl_oe[i]),
         .supply_switch_n(sw_o[i]), .supply_ctl(ctl[i])
      );
   end

   ssr_host_model i_ssr_host_model
   (
      .reset_oe(rst_oe), .fail_oe(pf_oe), .batt_oe(bl_oe),
      .reset_line(rst_line), .fail_line(pf_line), .batt_line(bl_line)
   );

   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic tally_and_finish;
      if (failures == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] seen,
                      input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Lands just after the edge so registered outputs have settled
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic wait_rel(output int n);
      n = 0;
      #1;
      while (rst_line !== 3'b111)
      begin
         step(1);
         n++;
         if (n > 4 * T)
         begin
            failures++;
            tally_and_finish();
         end
      end
   endtask

   task automatic t_power_up;
      int n;
      step(T / 2);
      chk("rst_early", rst_line, 3'b000);
      chk("bat_test", bl_line, 3'b001);
      wait_rel(n);
      chk("rst_len", n + T / 2 >= T, 1'b1);
      chk("sw_main", sw_o, 3'b000);
      chk("pf_ok", pf_line, 3'b111);
      chk("rst_level", rst_o, 3'b111);
      chk("pf_level", pf_o, 3'b111);
      chk("bl_level", bl_o, 3'b001);
   endtask

   task automatic t_mr;
      int n;
      // A three-clock glitch passes the synchroniser but not the debounce
      @(posedge ref_clk) sense.manual_reset_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      sense.manual_reset_n <= 1'b1;
      step(20);
      chk("mr_bounce", rst_line, 3'b111);
      @(posedge ref_clk) sense.manual_reset_n <= 1'b0;
      step(20);
      chk("mr_hold", rst_line, 3'b000);
      @(posedge ref_clk) sense.manual_reset_n <= 1'b1;
      wait_rel(n);
      chk("mr_len", n >= T && n <= T + 20, 1'b1);
   endtask

   task automatic t_pf;
      @(posedge ref_clk) sense.power_fail_sense_ok <= 1'b0;
      step(8);
      chk("pf_low", pf_line, 3'b000);
      @(posedge ref_clk) sense.power_fail_sense_ok <= 1'b1;
      step(8);
      chk("pf_high", pf_line, 3'b111);
   endtask

   task automatic t_alarm;
      @(posedge ref_clk) sense.security_alarm_n <= 1'b0;
      step(8);
      chk("alarm_sw", sw_o, 3'b110);
      chk("alarm_out", {ctl[2].out_ground, ctl[1].out_high_z,
          ctl[0].out_on, ctl[2].out_on, ctl[1].out_on}, 5'h1c);
      chk("tpu_on", {ctl[2].pullup_on, ctl[1].pullup_on}, 2'h3);
      @(posedge ref_clk) sense.security_alarm_n <= 1'b1;
      step(8);
      chk("alarm_end", sw_o, 3'b000);
   endtask

   task automatic t_brown;
      int n;
      @(posedge ref_clk) sense.vcc_above_reset <= 1'b0;
      step(8);
      chk("brown_rst", rst_line, 3'b000);
      chk("bat_rel", bl_line, 3'b111);
      @(posedge ref_clk) sense[8:6] <= 3'h0;
      step(10);
      chk("sw_batt", sw_o, 3'b111);
      chk("pf_batt", pf_line, 3'b000);
      chk("from_batt", {ctl[2].out_from_battery, ctl[1].out_from_battery,
          ctl[0].out_from_battery}, 3'h7);
      chk("ref_off", {ctl[0].reference_on, ctl[0].reference_pulldown},
          2'h1);
      chk("tpu_batt", {ctl[2].pullup_from_battery,
          ctl[1].pullup_from_battery}, 2'h3);
      @(posedge ref_clk) sense[8:7] <= 2'h3;
      step(8);
      chk("hyst", sw_o, 3'b111);
      @(posedge ref_clk) sense.vcc_above_switch_point <= 1'b1;
      step(8);
      chk("sw_back", sw_o, 3'b000);
      @(posedge ref_clk) sense.vcc_above_reset <= 1'b1;
      step(10);
      chk("bat_retest", bl_line, 3'b001);
      @(posedge ref_clk) sense.vcc_above_reset <= 1'b0;
      step(6);
      @(posedge ref_clk) sense.vcc_above_reset <= 1'b1;
      wait_rel(n);
      chk("timer_clear", n >= T, 1'b1);
   endtask

   initial
   begin
      failures = 0;
      checks = 0;
      rst_n = 1'b0;
      sense = 10'h3e7;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_power_up();
      t_mr();
      t_pf();
      t_alarm();
      t_brown();
      tally_and_finish();
   end
endmodule
